// ### include/gdil_map.vh
`ifndef GDIL_MAP_VH
`define GDIL_MAP_VH

// clock and timing figures
`define GDIL_CLK_PERIOD_NS  50
`define GDIL_T_WAKE_NS      280
`define GDIL_T_PWRUP_US     2000
`define GDIL_DT_STEP_CYC    8'h02

// register byte offsets
`define GDIL_REG_CMD        5'h00
`define GDIL_REG_RESP       5'h04
`define GDIL_REG_STATE      5'h08

// command upper nibbles
`define GDIL_OP_READ        4'h0
`define GDIL_OP_MASK_A      4'h2
`define GDIL_OP_MASK_B      4'h3
`define GDIL_OP_MODE        4'h4
`define GDIL_OP_CLR_A       4'h6
`define GDIL_OP_CLR_B       4'h7
`define GDIL_OP_DEAD        4'h8

// status-read selectors in the low nibble
`define GDIL_SEL_WORD_ONE   4'h0
`define GDIL_SEL_WORD_TWO   4'h1
`define GDIL_SEL_WORD_THREE 4'h2

// reset values
`define GDIL_MODE_RST       3'h1
`define GDIL_MASK_RST       8'h00
`define GDIL_DEAD_RST       4'h0

// flag positions
`define GDIL_FLG_FAULT      0
`define GDIL_FLG_STANDBY_STATE       1
`define GDIL_FLG_HI_EARLY   2
`define GDIL_FLG_LO_EARLY   3
`define GDIL_FLG_MODE_REF   4
`define GDIL_FLG_BAD_CMD    5

`endif

// ### core/gdil_sync.v
`timescale 1ns/10ps
`default_nettype none

module gdil_sync #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);

	reg [W-1:0] meta;

	// meta feeds only the second stage
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= {W{1'b0}};
			q_o  <= {W{1'b0}};
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule

`default_nettype wire

// ### core/gdil_top.v
`timescale 1ns/10ps
`default_nettype none
`include "gdil_map.vh"

module gdil_top #(
	parameter PWRUP_CYC = (`GDIL_T_PWRUP_US * 1000) / `GDIL_CLK_PERIOD_NS
) (
	input  wire        CLK_I,
	input  wire        RST_N_I,
	input  wire [4:0]  AVS_ADDRESS_I,
	input  wire        AVS_READ_I,
	input  wire        AVS_WRITE_I,
	input  wire [31:0] AVS_WRITEDATA_I,
	input  wire [3:0]  AVS_BYTEENABLE_I,
	output reg  [31:0] AVS_READDATA_O,
	output wire        AVS_WAITREQUEST_O,
	input  wire        ENABLE_PIN_ONE_I,
	input  wire        ENABLE_PIN_TWO_I,
	input  wire        PHASE_A_LOW_INPUT_I,
	input  wire        PHASE_B_LOW_INPUT_I,
	input  wire        PHASE_C_LOW_INPUT_I,
	input  wire        PHASE_A_HIGH_INPUT_N_I,
	input  wire        PHASE_B_HIGH_INPUT_N_I,
	input  wire        PHASE_C_HIGH_INPUT_N_I,
	input  wire        FAULT_I,
	output wire [2:0]  LOW_GATE_O,
	output wire [2:0]  HIGH_GATE_O,
	output reg  [2:0]  HIGH_DRIVE_LOWZ_O,
	output reg         STANDBY_O,
	output reg         READY_O,
	output reg         PUMP_EN_O
);

	localparam [1:0] PH_LOCK = 2'b00;
	localparam [1:0] PH_ARM  = 2'b01;
	localparam [1:0] PH_LIVE = 2'b10;

	// longest propagation: round down, at least one cycle
	localparam integer WAKE_RAW = `GDIL_T_WAKE_NS / `GDIL_CLK_PERIOD_NS;
	localparam integer WAKE_INT = (WAKE_RAW < 1) ? 1 : WAKE_RAW;
	localparam [3:0]   WAKE_CYC = WAKE_INT[3:0];
	localparam [15:0]  PU_CYC   = PWRUP_CYC[15:0];

	wire [8:0] pins_s;
	wire       en1_s;
	wire       en2_s;
	wire [2:0] lo_s;
	wire [2:0] hin_s;
	wire       fault_s;

	gdil_sync #(
		.W (9)
	) u_sync (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     ({FAULT_I, ENABLE_PIN_TWO_I, ENABLE_PIN_ONE_I,
		            PHASE_C_HIGH_INPUT_N_I, PHASE_B_HIGH_INPUT_N_I,
		            PHASE_A_HIGH_INPUT_N_I, PHASE_C_LOW_INPUT_I,
		            PHASE_B_LOW_INPUT_I, PHASE_A_LOW_INPUT_I}),
		.q_o     (pins_s)
	);

	assign lo_s    = pins_s[2:0];
	assign hin_s   = pins_s[5:3];
	assign en1_s   = pins_s[6];
	assign en2_s   = pins_s[7];
	assign fault_s = pins_s[8];

	reg  [2:0]  lo_prev;
	reg  [2:0]  hin_prev;
	reg  [15:0] pu_cnt;
	reg  [3:0]  wake_cnt;
	reg         awake;
	reg  [1:0]  ph_st [0:2];
	reg  [7:0]  flags;
	reg  [7:0]  irq_mask;
	reg  [2:0]  mode;
	reg         mode_lock;
	reg  [3:0]  dead;
	reg  [7:0]  last_cmd;
	reg  [7:0]  pend_rsp;
	reg  [7:0]  resp;
	reg         ack;

	wire       shutdown = ~awake | flags[`GDIL_FLG_FAULT];
	wire [2:0] lo_rise  = lo_s & ~lo_prev;
	wire [2:0] hin_fall = ~hin_s & hin_prev;
	wire [7:0] dead_cyc = {4'h0, dead} * `GDIL_DT_STEP_CYC;

	// power up after reset; enables are expected low meanwhile
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pu_cnt  <= 16'h0000;
			READY_O <= 1'b0;
		end else if (pu_cnt != PU_CYC) begin
			pu_cnt <= pu_cnt + 16'h0001;
		end else begin
			READY_O <= 1'b1;
		end
	end

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PUMP_EN_O <= 1'b0;
		end else begin
			PUMP_EN_O <= mode[0];
		end
	end

	// standby exit needs both enables held for the wake time
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wake_cnt  <= 4'h0;
			awake     <= 1'b0;
			STANDBY_O <= 1'b1;
			lo_prev   <= 3'h0;
			hin_prev  <= 3'h0; // same as synchroniser reset: no false fall
		end else begin
			lo_prev  <= lo_s;
			hin_prev <= hin_s;
			if (!(en1_s && en2_s) || !READY_O) begin
				wake_cnt <= 4'h0;
				awake    <= 1'b0;
			end else if (wake_cnt != WAKE_CYC) begin
				wake_cnt <= wake_cnt + 4'h1;
			end else begin
				awake <= 1'b1;
			end
			STANDBY_O <= ~awake;
		end
	end

	// per-phase lockout of the high-side driver
	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : g_phase
			always @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					ph_st[p] <= PH_LOCK;
				end else if (shutdown) begin
					ph_st[p] <= PH_LOCK;
				end else begin
					case (ph_st[p])
					PH_LOCK: begin
						// early high edge is simply ignored here
						if (lo_rise[p]) begin
							ph_st[p] <= PH_ARM;
						end
					end
					PH_ARM: begin
						if (hin_fall[p]) begin
							ph_st[p] <= PH_LIVE;
						end
					end
					PH_LIVE: begin
						ph_st[p] <= PH_LIVE;
					end
					default: begin
						ph_st[p] <= PH_LOCK;
					end
					endcase
				end
			end

			always @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					HIGH_DRIVE_LOWZ_O[p] <= 1'b0;
				end else begin
					HIGH_DRIVE_LOWZ_O[p] <= (ph_st[p] == PH_LIVE) &&
						!shutdown;
				end
			end
		end
	endgenerate

	// gate requests, then a dead-time on-delay per gate
	wire [5:0] req;
	wire [5:0] gate;

	generate
		for (p = 0; p < 3; p = p + 1) begin : g_req
			assign req[p]   = !shutdown && lo_s[p];
			assign req[p+3] = !shutdown && !hin_s[p] &&
				(ph_st[p] == PH_LIVE);
		end
		for (p = 0; p < 6; p = p + 1) begin : g_dead
			reg [7:0] cnt;
			reg       on;
			always @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					cnt <= 8'h00;
					on  <= 1'b0;
				end else if (!req[p]) begin
					cnt <= dead_cyc;
					on  <= 1'b0;
				end else if (cnt != 8'h00) begin
					cnt <= cnt - 8'h01;
				end else begin
					on <= 1'b1;
				end
			end
			assign gate[p] = on && !shutdown;
		end
	endgenerate

	assign LOW_GATE_O  = gate[2:0];
	assign HIGH_GATE_O = gate[5:3];

	// register bus: one wait cycle on every access
	wire req_bus = AVS_READ_I | AVS_WRITE_I;
	wire done    = req_bus & ack;
	wire cmd_wr  = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0] &
		(AVS_ADDRESS_I == `GDIL_REG_CMD);
	wire [7:0] cmd = AVS_WRITEDATA_I[7:0];

	assign AVS_WAITREQUEST_O = req_bus & ~ack;

	function [7:0] status_sel;
		input [3:0] sel;
		begin
			case (sel)
			`GDIL_SEL_WORD_ONE:   status_sel = flags;
			`GDIL_SEL_WORD_TWO:   status_sel = {mode_lock, mode, dead};
			`GDIL_SEL_WORD_THREE: status_sel = {2'b00, ph_st[2][1],
				ph_st[1][1], ph_st[0][1], ph_st[2][0], ph_st[1][0],
				ph_st[0][0]};
			default:              status_sel = 8'h00;
			endcase
		end
	endfunction

	wire [3:0] op       = cmd[7:4];
	wire       op_known = (op == `GDIL_OP_READ) || (op == `GDIL_OP_MASK_A) ||
		(op == `GDIL_OP_MASK_B) || (op == `GDIL_OP_MODE) ||
		(op == `GDIL_OP_CLR_A) || (op == `GDIL_OP_CLR_B) ||
		(op == `GDIL_OP_DEAD);

	// clear requests from the two clear commands, one flag group each
	reg [7:0] clr;
	reg [7:0] evt;
	always @* begin
		clr = 8'h00;
		if (cmd_wr && op == `GDIL_OP_CLR_A) begin
			clr[3:0] = cmd[3:0];
		end
		if (cmd_wr && op == `GDIL_OP_CLR_B) begin
			clr[7:4] = cmd[3:0];
		end
		evt = 8'h00;
		evt[`GDIL_FLG_FAULT]    = fault_s;
		evt[`GDIL_FLG_STANDBY_STATE]     = awake & ~(en1_s & en2_s);
		evt[`GDIL_FLG_HI_EARLY] = |(hin_fall & {ph_st[2] == PH_LOCK,
			ph_st[1] == PH_LOCK, ph_st[0] == PH_LOCK}) & ~shutdown;
		evt[`GDIL_FLG_LO_EARLY] = |lo_rise & ~awake;
		evt[`GDIL_FLG_MODE_REF] = cmd_wr & (op == `GDIL_OP_MODE) & mode_lock;
		evt[`GDIL_FLG_BAD_CMD]  = cmd_wr & ~op_known;
	end

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			flags <= 8'h00;
		end else begin
			// a new event beats a clear in the same cycle
			flags <= (flags & ~clr) | evt;
		end
	end

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			irq_mask  <= `GDIL_MASK_RST;
			mode      <= `GDIL_MODE_RST;
			mode_lock <= 1'b0;
			dead      <= `GDIL_DEAD_RST;
			last_cmd  <= 8'h00;
			pend_rsp  <= 8'h00;
			resp      <= 8'h00;
		end else if (cmd_wr) begin
			last_cmd <= cmd;
			// the frame shifts out what the previous frame asked for
			resp     <= pend_rsp;
			pend_rsp <= (op == `GDIL_OP_READ) ? status_sel(cmd[3:0]) :
				flags;
			if (op == `GDIL_OP_MASK_A || op == `GDIL_OP_MASK_B) begin
				irq_mask <= {3'h0, cmd[4:0]};
			end
			if (op == `GDIL_OP_MODE && !mode_lock) begin
				mode      <= cmd[3:1];
				mode_lock <= cmd[0];
			end
			if (op == `GDIL_OP_DEAD) begin
				dead <= cmd[3:0];
			end
		end
	end

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ack            <= 1'b0;
			AVS_READDATA_O <= 32'h00000000;
		end else begin
			ack <= req_bus & ~ack;
			if (AVS_READ_I && !ack) begin
				case (AVS_ADDRESS_I)
				`GDIL_REG_CMD:   AVS_READDATA_O <= {24'h000000, last_cmd};
				`GDIL_REG_RESP:  AVS_READDATA_O <= {24'h000000, resp};
				`GDIL_REG_STATE: AVS_READDATA_O <= {13'h0000,
					|(flags & ~irq_mask), READY_O, STANDBY_O, shutdown,
					HIGH_DRIVE_LOWZ_O, gate[5:3], gate[2:0],
					ph_st[2], ph_st[1], ph_st[0]};
				default:         AVS_READDATA_O <= 32'h00000000;
				endcase
			end else if (done) begin
				AVS_READDATA_O <= AVS_READDATA_O;
			end
		end
	end

endmodule

`default_nettype wire

// ### verification/gdil_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none

module gdil_chk_sva (
	input wire logic       CLK_I,
	input wire logic       RST_N_I,
	input wire logic       AVS_READ_I,
	input wire logic       AVS_WRITE_I,
	input wire logic       AVS_WAITREQUEST_O,
	input wire logic       ENABLE_PIN_ONE_I,
	input wire logic       ENABLE_PIN_TWO_I,
	input wire logic       FAULT_I,
	input wire logic [2:0] LOW_GATE_O,
	input wire logic [2:0] HIGH_GATE_O,
	input wire logic [2:0] HIGH_DRIVE_LOWZ_O,
	input wire logic       STANDBY_O,
	input wire logic       READY_O,
	input wire logic       PUMP_EN_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	shut_gates_a: assert property (
		STANDBY_O && $past(STANDBY_O) |->
		LOW_GATE_O == 3'h0 && HIGH_GATE_O == 3'h0)
		else $error("gate on in standby");
	fault_off_a: assert property (
		FAULT_I [*6] |->
		{LOW_GATE_O, HIGH_GATE_O, HIGH_DRIVE_LOWZ_O} == 9'h000)
		else $error("gates or drivers live during fault");
	lowz_clear_a: assert property (
		STANDBY_O [*2] |-> HIGH_DRIVE_LOWZ_O == 3'h0)
		else $error("high driver live in standby");
	high_live_a: assert property (
		(HIGH_GATE_O & ~HIGH_DRIVE_LOWZ_O) == 3'h0)
		else $error("locked high gate switched on");
	lowz_rise_a: assert property (
		(HIGH_DRIVE_LOWZ_O & ~$past(HIGH_DRIVE_LOWZ_O)) != 3'h0 |->
		!$past(STANDBY_O))
		else $error("driver armed asleep");
	wait_one_a: assert property (
		$rose(AVS_READ_I | AVS_WRITE_I) |->
		AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
		else $error("bad wait cycle");
	pump_on_a: assert property (
		$rose(RST_N_I) |-> ##[1:2] PUMP_EN_O)
		else $error("pump off after reset");
	ready_hold_a: assert property (
		READY_O |=> READY_O)
		else $error("ready dropped");
	wake_cause_a: assert property (
		$fell(STANDBY_O) |-> READY_O &&
		$past(ENABLE_PIN_ONE_I, 4) && $past(ENABLE_PIN_TWO_I, 4))
		else $error("bad wake");

	cover property (HIGH_DRIVE_LOWZ_O == 3'h7);
	cover property ($fell(PUMP_EN_O));
	cover property (FAULT_I [*6]);
endmodule

bind gdil_top gdil_chk_sva gdil_chk_sva_i (.CLK_I, .RST_N_I, .AVS_READ_I,
	.AVS_WRITE_I, .AVS_WAITREQUEST_O, .ENABLE_PIN_ONE_I, .ENABLE_PIN_TWO_I,
	.FAULT_I, .LOW_GATE_O, .HIGH_GATE_O, .HIGH_DRIVE_LOWZ_O, .STANDBY_O,
	.READY_O, .PUMP_EN_O);

`default_nettype wire

// ### verification/gdil_host.sv
`timescale 1ns/10ps
`default_nettype none

module gdil_host (
	input  wire logic       clk_i,
	output var  logic [1:0] en_o,
	output var  logic [2:0] low_o,
	output var  logic [2:0] high_n_o
);
	// enables stay low through reset; high-side inputs idle off
	initial begin
		en_o = 2'h0;
		low_o = 3'h0;
		high_n_o = 3'h7;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic set(input logic [2:0] lo, input logic [2:0] hn);
		@(posedge clk_i);
		low_o <= lo;
		high_n_o <= hn;
	endtask
	// settle time covers sync stages plus the wake filter
	task automatic wake(input logic v);
		@(posedge clk_i);
		en_o <= {v, v};
		cyc(12);
	endtask
	// short arming pulse, then a joint high-side toggle on every phase
	task automatic init(input logic [2:0] ph, input int d);
		set(ph, 3'h7);
		cyc(3);
		set(3'h0, 3'h7);
		cyc(2);
		set(3'h0, 3'h0);
		cyc(d * 2 + 4);
		set(3'h0, 3'h7);
		cyc(6);
	endtask
endmodule

`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "gdil_map.vh"

module tb;
	logic        CLK_I;
	logic        RST_N_I;
	logic [4:0]  AVS_ADDRESS_I;
	logic        AVS_READ_I;
	logic        AVS_WRITE_I;
	logic [31:0] AVS_WRITEDATA_I;
	logic [3:0]  AVS_BYTEENABLE_I;
	logic        FAULT_I;
	wire  [31:0] AVS_READDATA_O;
	wire         AVS_WAITREQUEST_O;
	wire  [2:0]  LOW_GATE_O;
	wire  [2:0]  HIGH_GATE_O;
	wire  [2:0]  HIGH_DRIVE_LOWZ_O;
	wire         STANDBY_O;
	wire         READY_O;
	wire         PUMP_EN_O;
	wire  [1:0]  en;
	wire  [2:0]  lo;
	wire  [2:0]  hi_n;
	logic [31:0] rd;
	int          n_errors = 0;
	int          comparisons = 0;
	int          k;

	always #25 CLK_I = ~CLK_I;

	gdil_top #(.PWRUP_CYC(20)) gdil_top_i (.CLK_I, .RST_N_I, .AVS_ADDRESS_I,
		.AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I,
		.AVS_READDATA_O, .AVS_WAITREQUEST_O, .ENABLE_PIN_ONE_I(en[0]),
		.ENABLE_PIN_TWO_I(en[1]), .PHASE_A_LOW_INPUT_I(lo[0]),
		.PHASE_B_LOW_INPUT_I(lo[1]), .PHASE_C_LOW_INPUT_I(lo[2]),
		.PHASE_A_HIGH_INPUT_N_I(hi_n[0]), .PHASE_B_HIGH_INPUT_N_I(hi_n[1]),
		.PHASE_C_HIGH_INPUT_N_I(hi_n[2]), .FAULT_I, .LOW_GATE_O, .HIGH_GATE_O,
		.HIGH_DRIVE_LOWZ_O, .STANDBY_O, .READY_O, .PUMP_EN_O);
	gdil_host gdil_host_i (.clk_i(CLK_I), .en_o(en), .low_o(lo), .high_n_o(hi_n));

	task automatic summarize;
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one idle edge first so back-to-back calls never retouch a strobe
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int          n;
		logic        busy;
		logic [31:0] got;
		n = 0;
		busy = 1'h1;
		got = 32'h0;
		@(posedge CLK_I);
		AVS_READ_I <= !w;
		AVS_WRITE_I <= w;
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= {24'h0, d};
		AVS_BYTEENABLE_I <= 4'hf;
		// sampled mid-cycle: both stand unchanged up to the next rising edge
		do begin
			@(negedge CLK_I);
			busy = AVS_WAITREQUEST_O;
			got = AVS_READDATA_O;
			n++;
			@(posedge CLK_I);
		end while (busy !== 1'h0 && n < 50);
		rd = got;
		AVS_READ_I <= 1'h0;
		AVS_WRITE_I <= 1'h0;
		if (n >= 50) begin
			n_errors++;
			summarize();
		end
	endtask

	initial begin
		CLK_I = 1'h0;
		RST_N_I = 1'h0;
		AVS_ADDRESS_I = 5'h00;
		AVS_READ_I = 1'h0;
		AVS_WRITE_I = 1'h0;
		AVS_WRITEDATA_I = 32'h0;
		AVS_BYTEENABLE_I = 4'h0;
		FAULT_I = 1'h0;
		repeat (2) @(posedge CLK_I);
		RST_N_I <= 1'h1;
		for (k = 0; k < 200 && READY_O !== 1'h1; k++) @(posedge CLK_I);
		if (k == 200) begin
			n_errors++;
			summarize();
		end
		chk(10'(PUMP_EN_O), 10'h001);
		chk({1'h0, STANDBY_O, 2'h0, LOW_GATE_O, HIGH_GATE_O}, 10'h100);
		bus(1'h1, `GDIL_REG_CMD, 8'h80);
		gdil_host_i.wake(1'h1);
		chk(10'(STANDBY_O), 10'h000);
		gdil_host_i.init(3'h0, 0);
		chk(10'(HIGH_DRIVE_LOWZ_O), 10'h000);
		bus(1'h1, `GDIL_REG_CMD, 8'h3f);
		bus(1'h0, `GDIL_REG_STATE, 8'h00);
		chk(10'(rd[18]), 10'h000);
		bus(1'h1, `GDIL_REG_CMD, 8'h20);
		bus(1'h0, `GDIL_REG_STATE, 8'h00);
		chk(10'(rd[18]), 10'h001);
		bus(1'h1, `GDIL_REG_CMD, 8'h6f);
		bus(1'h1, `GDIL_REG_CMD, 8'h7f);
		bus(1'h0, `GDIL_REG_STATE, 8'h00);
		chk(10'(rd[18]), 10'h000);
		bus(1'h1, `GDIL_REG_CMD, 8'hf0);
		bus(1'h0, `GDIL_REG_STATE, 8'h00);
		chk(10'(rd[18]), 10'h001);
		gdil_host_i.init(3'h7, 0);
		chk({1'h0, HIGH_DRIVE_LOWZ_O, 3'h0, HIGH_GATE_O}, 10'h1c0);
		bus(1'h1, `GDIL_REG_CMD, 8'h82);
		gdil_host_i.set(3'h1, 3'h5);
		gdil_host_i.cyc(4);
		chk({4'h0, LOW_GATE_O, HIGH_GATE_O}, 10'h000);
		gdil_host_i.cyc(6);
		chk({4'h0, LOW_GATE_O, HIGH_GATE_O}, 10'h00a);
		gdil_host_i.set(3'h0, 3'h7);
		bus(1'h1, `GDIL_REG_CMD, 8'h41);
		gdil_host_i.cyc(2);
		chk(10'(PUMP_EN_O), 10'h000);
		bus(1'h1, `GDIL_REG_CMD, 8'h43);
		gdil_host_i.cyc(2);
		chk(10'(PUMP_EN_O), 10'h000);
		bus(1'h1, `GDIL_REG_CMD, 8'h01);
		bus(1'h1, `GDIL_REG_CMD, 8'h00);
		bus(1'h0, `GDIL_REG_RESP, 8'h00);
		chk(10'(rd[7:0]), 10'h082);
		@(posedge CLK_I);
		FAULT_I <= 1'h1;
		gdil_host_i.cyc(8);
		chk({1'h0, HIGH_DRIVE_LOWZ_O, LOW_GATE_O, HIGH_GATE_O}, 10'h000);
		FAULT_I <= 1'h0;
		gdil_host_i.cyc(6);
		bus(1'h1, `GDIL_REG_CMD, 8'h6f);
		bus(1'h1, `GDIL_REG_CMD, 8'h7f);
		gdil_host_i.init(3'h1, 2);
		chk(10'(HIGH_DRIVE_LOWZ_O), 10'h001);
		gdil_host_i.set(3'h6, 3'h7);
		gdil_host_i.cyc(3);
		gdil_host_i.set(3'h0, 3'h1);
		gdil_host_i.cyc(6);
		chk(10'(HIGH_DRIVE_LOWZ_O), 10'h007);
		gdil_host_i.set(3'h0, 3'h7);
		gdil_host_i.wake(1'h0);
		chk({3'h0, STANDBY_O, 3'h0, HIGH_DRIVE_LOWZ_O}, 10'h040);
		summarize();
	end
endmodule

`default_nettype wire
